// [logic/sor_router.sv]
// How it works
// - Digit 0 none, 1..3 pick terminal pair
// - Word one: done1, speed match, turning, ready
// - Word two: current, speed cap, brake, warning
// - Word three digit 0 routes done2
// - Closed loop error limit 0..32767, reset 0
// - Each 4-bit digit decoded independently
`timescale 1ns/1ps
`default_nettype none
module sor_router (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [sor_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [sor_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [sor_pkg::DATA_W-1:0] reg_rdata,
    input wire logic position_done_one,
    input wire logic speed_match_flag,
    input wire logic motor_turning_flag,
    input wire logic drive_ready_flag,
    input wire logic current_cap_flag,
    input wire logic speed_cap_flag,
    input wire logic brake_interlock_out,
    input wire logic warning_flag,
    input wire logic position_done_two,
    output logic [sor_pkg::NUM_PAIR-1:0] pair_out,
    output logic [14:0] error_limit,
    output logic irq
);
    import sor_pkg::*;

    typedef struct packed {
        logic [15:0] sel_one;
        logic [15:0] sel_two;
        logic [15:0] sel_three;
        logic [15:0] pol;
        logic [15:0] err_limit;
        logic [15:0] act_one;
        logic [15:0] act_two;
        logic [15:0] act_three;
        logic [15:0] act_pol;
        logic [15:0] act_limit;
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] mask;
        logic [NUM_PAIR-1:0] pins;
        logic [15:0] rdata;
    } sor_state_t;

    sor_state_t st_r;
    sor_state_t st_nxt;

    logic [NUM_SIG-1:0] sig_vec;
    logic [NUM_SIG*DIGIT_W-1:0] dig_vec;
    logic [NUM_PAIR-1:0] pair_raw;
    logic [NUM_PAIR-1:0] pol_act;
    logic apply_req;
    logic bad_cfg;

    assign sig_vec = {position_done_two, warning_flag, brake_interlock_out, speed_cap_flag,
                      current_cap_flag, drive_ready_flag, motor_turning_flag, speed_match_flag,
                      position_done_one};
    // Routing follows the applied copy so edits made at run time do not glitch the pins
    assign dig_vec = {st_r.act_three[3:0], st_r.act_two, st_r.act_one};

    // Several signals on one pair are ORed: the pair leaves its polarity level if any routed signal is on
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PAIR; gp++) begin : g_pair
            logic [NUM_SIG-1:0] hit;
            genvar gs;
            for (gs = 0; gs < NUM_SIG; gs++) begin : g_sig
                assign hit[gs] = sig_vec[gs] &&
                    (dig_vec[gs*DIGIT_W +: DIGIT_W] == 4'(gp + 1));
            end
            assign pair_raw[gp] = |hit;
            // Each pair owns a whole polarity digit; only its low bit carries meaning
            assign pol_act[gp] = st_r.act_pol[gp*DIGIT_W];
        end
    endgenerate

    // Digits 4..F are outside the allowed range; flag them for software
    always_comb begin
        bad_cfg = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (st_r.sel_one[i*DIGIT_W +: DIGIT_W] > 4'h3 || st_r.sel_two[i*DIGIT_W +: DIGIT_W] > 4'h3) begin
                bad_cfg = 1'b1;
            end
        end
        if (st_r.sel_three[3:0] > 4'h3 || st_r.sel_three[15:4] != 12'h000) begin
            bad_cfg = 1'b1;
        end
    end

    assign apply_req = reg_wr && reg_addr == OFS_APPLY && reg_wdata[0];

    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 16'h0000;
        st_nxt.pins = pair_raw ^ pol_act;
        if (reg_wr) begin
            case (reg_addr)
                OFS_SEL_ONE: st_nxt.sel_one = reg_wdata;
                OFS_SEL_TWO: st_nxt.sel_two = reg_wdata;
                OFS_SEL_THREE: st_nxt.sel_three = reg_wdata;
                OFS_POL: st_nxt.pol = reg_wdata;
                OFS_ERR_LIMIT: st_nxt.err_limit = {1'b0, reg_wdata[14:0]};
                OFS_IRQ_STATUS: st_nxt.status = st_r.status & ~reg_wdata[IRQ_W-1:0];
                OFS_IRQ_MASK: st_nxt.mask = reg_wdata[IRQ_W-1:0];
                default: ;
            endcase
        end
        // Set wins over a same-cycle write-one clear
        if (bad_cfg) begin
            st_nxt.status[IRQ_BIT_BADCFG] = 1'b1;
        end
        // Applying stands in for the power restart the settings wait on
        if (apply_req) begin
            st_nxt.act_one = st_r.sel_one;
            st_nxt.act_two = st_r.sel_two;
            st_nxt.act_three = st_r.sel_three;
            st_nxt.act_pol = st_r.pol;
            st_nxt.act_limit = st_r.err_limit;
            st_nxt.status[IRQ_BIT_APPLY] = 1'b1;
        end
        if (reg_rd) begin
            case (reg_addr)
                OFS_SEL_ONE: st_nxt.rdata = st_r.sel_one;
                OFS_SEL_TWO: st_nxt.rdata = st_r.sel_two;
                OFS_SEL_THREE: st_nxt.rdata = st_r.sel_three;
                OFS_SPARE: st_nxt.rdata = RST_SPARE;
                OFS_POL: st_nxt.rdata = st_r.pol;
                OFS_ERR_LIMIT: st_nxt.rdata = st_r.err_limit;
                OFS_IRQ_STATUS: st_nxt.rdata = {14'h0000, st_r.status};
                OFS_IRQ_MASK: st_nxt.rdata = {14'h0000, st_r.mask};
                OFS_PIN_STATE: st_nxt.rdata = {13'h0000, st_r.pins};
                default: st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.sel_one <= RST_SEL_ONE;
            st_r.sel_two <= RST_SEL_TWO;
            st_r.sel_three <= RST_SEL_THREE;
            st_r.pol <= RST_POL;
            st_r.err_limit <= RST_ERR_LIMIT;
            st_r.act_one <= RST_SEL_ONE;
            st_r.act_two <= RST_SEL_TWO;
            st_r.act_three <= RST_SEL_THREE;
            st_r.act_pol <= RST_POL;
            st_r.act_limit <= RST_ERR_LIMIT;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign pair_out = st_r.pins;
    assign error_limit = st_r.act_limit[14:0];
    assign irq = |(st_r.status & st_r.mask);

    property p_route_one;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.act_one[3:0] == 4'h1 && position_done_one && st_r.act_pol[0] == 1'b0)
            |=> pair_out[0];
    endproperty
    a_route_one: assert property (p_route_one) else $error("done1 not on pair 0");

    property p_none_quiet;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.act_one == 16'h0000 && st_r.act_two == 16'h0000 && st_r.act_three[3:0] == 4'h0)
            |=> pair_out == $past(pol_act);
    endproperty
    a_none_quiet: assert property (p_none_quiet) else $error("unrouted signal drove a pair");

    property p_ready_pair;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.act_one[15:12] == 4'h3 && drive_ready_flag && !pol_act[2]) |=> pair_out[2];
    endproperty
    a_ready_pair: assert property (p_ready_pair) else $error("ready not on pair 2");

    property p_warn_pair;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.act_two[15:12] == 4'h2 && warning_flag) |=> pair_out[1] != $past(pol_act[1]);
    endproperty
    a_warn_pair: assert property (p_warn_pair) else $error("warning not on pair 1");

    property p_done_two;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.act_three[3:0] == 4'h1 && position_done_two && !st_r.act_pol[0]) |=> pair_out[0];
    endproperty
    a_done_two: assert property (p_done_two) else $error("done2 not on pair 0");

    property p_limit_range;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == OFS_ERR_LIMIT)
            |=> st_r.err_limit == ($past(reg_wdata) & ERR_LIMIT_MAX);
    endproperty
    a_limit_range: assert property (p_limit_range) else $error("limit readback wrong");

    property p_pol_wait;
        @(posedge core_clk) disable iff (!rst_n)
        !apply_req |=> $stable(st_r.act_pol) && $stable(st_r.act_one) && $stable(st_r.act_two);
    endproperty
    a_pol_wait: assert property (p_pol_wait) else $error("polarity applied early");

    property p_spare_read;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == OFS_SPARE) |=> reg_rdata == 16'h8888;
    endproperty
    a_spare_read: assert property (p_spare_read) else $error("spare word wrong");

    property p_route_speed;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.act_one[7:4] == 4'h1 && speed_match_flag && !pol_act[0]) |=> pair_out[0];
    endproperty
    a_route_speed: assert property (p_route_speed) else $error("speed match not on pair 0");

    property p_route_turning;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.act_one[11:8] == 4'h3 && motor_turning_flag && !pol_act[2]) |=> pair_out[2];
    endproperty
    a_route_turning: assert property (p_route_turning) else $error("turning not on pair 2");

    property p_route_current;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.act_two[3:0] == 4'h1 && current_cap_flag && !pol_act[0]) |=> pair_out[0];
    endproperty
    a_route_current: assert property (p_route_current) else $error("current cap not on pair 0");

    property p_route_speed_cap;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.act_two[7:4] == 4'h3 && speed_cap_flag && !pol_act[2]) |=> pair_out[2];
    endproperty
    a_route_speed_cap: assert property (p_route_speed_cap) else $error("speed cap not on pair 2");

    property p_route_brake;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.act_two[11:8] == 4'h1 && brake_interlock_out && !pol_act[0]) |=> pair_out[0];
    endproperty
    a_route_brake: assert property (p_route_brake) else $error("brake not on pair 0");

    property p_done_two_far;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.act_three[3:0] == 4'h3 && position_done_two && !pol_act[2]) |=> pair_out[2];
    endproperty
    a_done_two_far: assert property (p_done_two_far) else $error("done2 not on pair 2");

    property p_invert_on;
        @(posedge core_clk) disable iff (!rst_n)
        (pol_act[1] && sig_vec == 9'h000) |=> pair_out[1];
    endproperty
    a_invert_on: assert property (p_invert_on) else $error("inverted idle pair low");

    property p_invert_off;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.act_one[3:0] == 4'h2 && position_done_one && pol_act[1]) |=> !pair_out[1];
    endproperty
    a_invert_off: assert property (p_invert_off) else $error("inverted active pair high");

    property p_idle_level;
        @(posedge core_clk) disable iff (!rst_n)
        sig_vec == 9'h000 |=> pair_out == $past(pol_act);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle pairs not at polarity level");

    property p_wide_digit;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.act_one[3:0] > 4'h3 && sig_vec == 9'h001) |=> pair_out == $past(pol_act);
    endproperty
    a_wide_digit: assert property (p_wide_digit) else $error("digit above 3 routed");

    property p_digit_zero;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.act_one[3:0] == 4'h0 && sig_vec == 9'h001) |=> pair_out == $past(pol_act);
    endproperty
    a_digit_zero: assert property (p_digit_zero) else $error("digit 0 routed");

    property p_read_one;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == OFS_SEL_ONE) |=> reg_rdata == $past(st_r.sel_one);
    endproperty
    a_read_one: assert property (p_read_one) else $error("word one readback wrong");

    property p_write_one;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == OFS_SEL_ONE) |=> st_r.sel_one == $past(reg_wdata);
    endproperty
    a_write_one: assert property (p_write_one) else $error("word one not stored");

    property p_write_two;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == OFS_SEL_TWO) |=> st_r.sel_two == $past(reg_wdata);
    endproperty
    a_write_two: assert property (p_write_two) else $error("word two not stored");

    property p_write_three;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == OFS_SEL_THREE) |=> st_r.sel_three == $past(reg_wdata);
    endproperty
    a_write_three: assert property (p_write_three) else $error("word three not stored");

    property p_apply_routes;
        @(posedge core_clk) disable iff (!rst_n)
        apply_req |=> st_r.act_one == $past(st_r.sel_one) && st_r.act_two == $past(st_r.sel_two)
            && st_r.act_three == $past(st_r.sel_three) && st_r.act_pol == $past(st_r.pol);
    endproperty
    a_apply_routes: assert property (p_apply_routes) else $error("apply did not copy settings");

    property p_apply_limit;
        @(posedge core_clk) disable iff (!rst_n)
        apply_req |=> error_limit == $past(st_r.err_limit[14:0]);
    endproperty
    a_apply_limit: assert property (p_apply_limit) else $error("apply did not copy limit");

    property p_limit_hold;
        @(posedge core_clk) disable iff (!rst_n)
        !apply_req |=> $stable(error_limit);
    endproperty
    a_limit_hold: assert property (p_limit_hold) else $error("limit moved without apply");

    property p_limit_top;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == OFS_ERR_LIMIT) |=> !st_r.err_limit[15];
    endproperty
    a_limit_top: assert property (p_limit_top) else $error("limit above 32767");

    property p_read_limit;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == OFS_ERR_LIMIT) |=> reg_rdata == $past(st_r.err_limit);
    endproperty
    a_read_limit: assert property (p_read_limit) else $error("limit readback wrong");

    property p_pin_read;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == OFS_PIN_STATE) |=> reg_rdata == {13'h0, $past(pair_out)};
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin state readback wrong");

    property p_bad_flag;
        @(posedge core_clk) disable iff (!rst_n)
        bad_cfg |=> st_r.status[IRQ_BIT_BADCFG];
    endproperty
    a_bad_flag: assert property (p_bad_flag) else $error("bad digit not flagged");

    property p_pol_read;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == OFS_POL) |=> reg_rdata == $past(st_r.pol);
    endproperty
    a_pol_read: assert property (p_pol_read) else $error("polarity readback wrong");
endmodule
`default_nettype wire

// [logic/sor_pkg.sv]
`default_nettype none
package sor_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] OFS_SEL_ONE = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_SEL_TWO = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_SEL_THREE = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_SPARE = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_POL = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_ERR_LIMIT = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_APPLY = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_PIN_STATE = 4'h9;
    localparam logic [15:0] RST_SEL_ONE = 16'h3211;
    localparam logic [15:0] RST_SEL_TWO = 16'h0000;
    localparam logic [15:0] RST_SEL_THREE = 16'h0000;
    localparam logic [15:0] RST_SPARE = 16'h8888;
    localparam logic [15:0] RST_POL = 16'h0000;
    localparam logic [15:0] RST_ERR_LIMIT = 16'h0000;
    localparam logic [15:0] ERR_LIMIT_MAX = 16'h7fff;
    localparam int DIGIT_W = 4;
    localparam int NUM_SIG = 9;
    localparam int NUM_PAIR = 3;
    localparam logic [3:0] DEST_NONE = 4'h0;
    localparam int IRQ_W = 2;
    localparam int IRQ_BIT_APPLY = 0;
    localparam int IRQ_BIT_BADCFG = 1;
endpackage
`default_nettype wire

// [tb/sor_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sor_ctrl_model (
    input wire logic core_clk,
    input wire logic [2:0] pair_lvl,
    output logic [2:0] pair_seen
);
    // The controller only latches the terminal levels; it never drives back
    always_ff @(posedge core_clk) begin
        pair_seen <= pair_lvl;
    end
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sor_pkg::*;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic [ADDR_W-1:0] reg_addr = 4'h0;
    logic [DATA_W-1:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [DATA_W-1:0] reg_rdata;
    logic [8:0] st = 9'h000;
    logic [2:0] pair_out;
    logic [2:0] pair_seen;
    logic [14:0] error_limit;
    logic irq;
    int fail_count = 0;
    int cmp_count = 0;
    sor_router u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .position_done_one(st[0]),
        .speed_match_flag(st[1]), .motor_turning_flag(st[2]), .drive_ready_flag(st[3]),
        .current_cap_flag(st[4]), .speed_cap_flag(st[5]), .brake_interlock_out(st[6]),
        .warning_flag(st[7]), .position_done_two(st[8]), .pair_out(pair_out),
        .error_limit(error_limit), .irq(irq));
    sor_ctrl_model u_ctrl (.core_clk(core_clk), .pair_lvl(pair_out), .pair_seen(pair_seen));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 chk(what, reg_rdata, exp);
    endtask
    task automatic t_reset_values;
        rd_chk("sel_one", OFS_SEL_ONE, 16'h3211);
        rd_chk("sel_two", OFS_SEL_TWO, 16'h0000);
        rd_chk("sel_three", OFS_SEL_THREE, 16'h0000);
        rd_chk("spare", OFS_SPARE, 16'h8888);
        rd_chk("pol", OFS_POL, 16'h0000);
        rd_chk("limit", OFS_ERR_LIMIT, 16'h0000);
        rd_chk("unmapped", 4'hf, 16'h0000);
        chk("error_limit", {1'h0, error_limit}, 16'h0000);
    endtask
    task automatic t_limit;
        wr(OFS_ERR_LIMIT, 16'hffff);
        rd_chk("limit", OFS_ERR_LIMIT, 16'h7fff);
        chk("staged limit", {1'h0, error_limit}, 16'h0000);
        wr(OFS_APPLY, 16'h0001);
        repeat (2) @(posedge core_clk);
        #1 chk("error_limit", {1'h0, error_limit}, 16'h7fff);
    endtask
    task automatic t_route;
        logic [2:0] e;
        wr(OFS_POL, 16'h0010);
        st <= 9'h001;
        repeat (3) @(posedge core_clk);
        #1 chk("unapplied pol", {13'h0, pair_out}, 16'h0001);
        for (int c = 0; c < 4; c++) begin
            wr(OFS_SEL_ONE, {4{c[3:0]}});
            wr(OFS_SEL_TWO, {4{c[3:0]}});
            wr(OFS_SEL_THREE, {12'h000, c[3:0]});
            wr(OFS_APPLY, 16'h0001);
            e = (c == 0) ? 3'h0 : 3'h1 << (c - 1);
            for (int i = 0; i < 9; i++) begin
                @(posedge core_clk);
                st <= 9'h001 << i;
                repeat (3) @(posedge core_clk);
                #1 chk("pair_out", {13'h0, pair_out}, {13'h0, e ^ 3'h2});
                chk("pair_seen", {13'h0, pair_seen}, {13'h0, e ^ 3'h2});
            end
        end
        @(posedge core_clk);
        st <= 9'h000;
        repeat (3) @(posedge core_clk);
        #1 chk("idle pair_out", {13'h0, pair_out}, 16'h0002);
        rd_chk("pin state", OFS_PIN_STATE, 16'h0002);
    endtask
    task automatic t_irq;
        chk("masked irq", {15'h0, irq}, 16'h0000);
        rd_chk("status", OFS_IRQ_STATUS, 16'h0001);
        wr(OFS_IRQ_MASK, 16'h0001);
        #1 chk("irq", {15'h0, irq}, 16'h0001);
        wr(OFS_IRQ_STATUS, 16'h0001);
        #1 chk("cleared irq", {15'h0, irq}, 16'h0000);
        rd_chk("status", OFS_IRQ_STATUS, 16'h0000);
    endtask
    task automatic t_bad_digit;
        wr(OFS_SEL_ONE, 16'h3214);
        wr(OFS_APPLY, 16'h0001);
        st <= 9'h001;
        repeat (3) @(posedge core_clk);
        #1 chk("digit 4 pair_out", {13'h0, pair_out}, 16'h0002);
        rd_chk("bad status", OFS_IRQ_STATUS, 16'h0003);
        wr(OFS_IRQ_STATUS, 16'h0002);
        rd_chk("held status", OFS_IRQ_STATUS, 16'h0003);
        wr(OFS_SEL_ONE, 16'h3211);
        wr(OFS_IRQ_STATUS, 16'h0003);
        rd_chk("clean status", OFS_IRQ_STATUS, 16'h0000);
    endtask
    task automatic t_mid_reset;
        @(posedge core_clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge core_clk);
        #1 chk("reset pair_out", {13'h0, pair_out}, 16'h0000);
        chk("reset error_limit", {1'h0, error_limit}, 16'h0000);
        chk("reset irq", {15'h0, irq}, 16'h0000);
        @(posedge core_clk);
        rst_n <= 1'h1;
        rd_chk("reset sel_one", OFS_SEL_ONE, 16'h3211);
        rd_chk("reset pol", OFS_POL, 16'h0000);
        repeat (2) @(posedge core_clk);
        #1 chk("restart pair_out", {13'h0, pair_out}, 16'h0001);
        @(posedge core_clk);
        st <= 9'h000;
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #500000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'h1;
        t_reset_values();
        t_limit();
        t_route();
        t_irq();
        t_bad_digit();
        t_mid_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
